// >>> common/sewp_regs.vh
// Function
// - Serial data is sampled on the rising clock edge and changed after the falling edge.
// - The data line is only ever pulled low or released, never driven high.
// - The three strap inputs are matched against the select bits of the device byte.
// - Strap inputs that are left unconnected count as low.
// - A high write protect level blocks every write; a low level allows normal work.
// - The main array is 128 pages of 32 bytes, reached by the low 12 bits of the 13-bit word address.
// - Page writes of up to 32 bytes in one page are taken, and shorter ones too.
// - Each write cycle not blocked by write protect is self-timed and lasts 5 ms once the buffer has drained.
// - A separate 32-byte security sector stays writable until it is locked.
// - A 128-bit unique identifier is readable and never writable.
// - Type code 1010 reaches the main array and 1011 the sector, identifier and lock.
// - Under 1011 with address bits 10:9 at 00 the sector is chosen, indexed by bits 4:0.
// - Under 1011 with address bits 10:9 at 01 the identifier is chosen, indexed by bits 3:0.
// - Under 1011 with address bits 10:9 at 10 the single lock flag is chosen.
`ifndef SEWP_REGS_VH
`define SEWP_REGS_VH

// ----------------------------------------------------------------
// Device byte layout and space codes
// ----------------------------------------------------------------
`define CODE_MAIN     4'hA
`define CODE_SEC      4'hB
`define DEVB_CODE_MSB 7
`define DEVB_CODE_LSB 4
`define DEVB_SEL_MSB  3
`define DEVB_SEL_LSB  1
`define DEVB_RW_BIT   0
`define DEVB_SPACE    4

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define ADDR_W        13
`define MAIN_AW       12
`define SEC_AW        5
`define AHI_W         5
`define REG_MSB       10
`define REG_LSB       9
`define REGION_SEC    2'h0
`define REGION_UID    2'h1
`define REGION_LOCK   2'h2
`define MASK_MAIN     13'h0FFF
`define MASK_PAGE     13'h001F
`define MASK_UID      13'h000F
`define MASK_NONE     13'h0000
`define ADDR_ONE      13'h0001
`define UID_BITS      128
`define UNMAPPED_BYTE 8'hFF

// ----------------------------------------------------------------
// Bit timing, buffer and write cycle
// ----------------------------------------------------------------
`define BIT_FIRST     4'h0
`define BIT_ACK       4'h8
`define BIT_ONE       4'h1
`define BIT_TOP       3'h7
`define FIFO_DEPTH    32
`define T_WR_MS       5
`define CLK_KHZ       100000

`endif

// >>> core/sewp_fifo.v
`timescale 1ns/100ps
// Small synchronous FIFO with valid and ready on both sides.
module sewp_fifo #(
  parameter DW    = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
)(
  clk,
  reset,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input  wire          clk;
  input  wire          reset;
  input  wire          in_valid;
  output wire          in_ready;
  input  wire [DW-1:0] in_data;
  output wire          out_valid;
  input  wire          out_ready;
  output wire [DW-1:0] out_data;

  reg [DW-1:0] buf_q [0:DEPTH-1];
  reg [AW:0]   wr_q;
  reg [AW:0]   rd_q;

  // One spare pointer bit tells full from empty.
  assign out_valid = (wr_q != rd_q);
  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_data  = buf_q[rd_q[AW-1:0]];

  always @(posedge clk) begin
    if (reset) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        buf_q[wr_q[AW-1:0]] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// >>> core/sewp_mem.v
`timescale 1ns/100ps
// Byte array with one write port and a registered read port.
module sewp_mem #(
  parameter AW = 12,
  parameter DW = 8
)(
  clk,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input  wire          clk;
  input  wire          we;
  input  wire [AW-1:0] waddr;
  input  wire [DW-1:0] wdata;
  input  wire [AW-1:0] raddr;
  output reg  [DW-1:0] rdata;

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Cells hold no reset, as a real array keeps its content.
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// >>> core/sewp_top.v
`timescale 1ns/100ps
`include "sewp_regs.vh"
// Two-wire serial EEPROM storage core, oversampling the bus on mclk.
module sewp_top #(
  parameter         WR_CYCLES = `T_WR_MS * `CLK_KHZ,
  parameter         CNT_W     = 20,
  // Identifier value is arbitrary.
  parameter [127:0] UID_VALUE = 128'h00112233445566778899AABBCCDDEEFF
)(
  mclk,
  reset,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  device_select_straps,
  write_protect,
  write_busy,
  security_lock_flag
);
  input  wire       mclk;
  input  wire       reset;
  input  wire       scl_in;
  input  wire       sda_in;
  output wire       sda_out;
  output wire       sda_oe;
  input  wire [2:0] device_select_straps;
  input  wire       write_protect;
  output wire       write_busy;
  output wire       security_lock_flag;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DEV  = 3'h1;
  localparam [2:0] S_AHI  = 3'h2;
  localparam [2:0] S_ALO  = 3'h3;
  localparam [2:0] S_WR   = 3'h4;
  localparam [2:0] S_RD   = 3'h5;

  localparam [1:0] W_IDLE  = 2'h0;
  localparam [1:0] W_DRAIN = 2'h1;
  localparam [1:0] W_TIME  = 2'h2;

  localparam integer     WR_LAST_I = WR_CYCLES - 1;
  localparam [CNT_W-1:0] WR_LAST   = WR_LAST_I[CNT_W-1:0];

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Step an address inside the bits that the mask leaves free.
  function [`ADDR_W-1:0] addr_step;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] m;
    begin
      addr_step = (a & ~m) | ((a + `ADDR_ONE) & m);
    end
  endfunction

  // Wrap mask for a space; main array reads run across pages, writes stay in one.
  function [`ADDR_W-1:0] wrap_mask;
    input               sec;
    input [`ADDR_W-1:0] a;
    input               rd;
    begin
      if (!sec) begin
        wrap_mask = rd ? `MASK_MAIN : `MASK_PAGE;
      end else begin
        case (a[`REG_MSB:`REG_LSB])
          `REGION_UID:  wrap_mask = `MASK_UID;
          `REGION_LOCK: wrap_mask = `MASK_NONE;
          default:      wrap_mask = `MASK_PAGE;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg       scl_prev_q;
  reg       sda_prev_q;
  reg [2:0] strap_meta_q;
  reg [2:0] strap_q;
  reg       wp_meta_q;
  reg       wp_q;

  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];

  // Every pin passes two flops; only the second stage is read.
  // Unconnected straps are pulled low on the board, so low is the idle value.
  always @(posedge mclk) begin
    if (reset) begin
      scl_sync_q   <= 2'h3;
      sda_sync_q   <= 2'h3;
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
      strap_meta_q <= 3'h0;
      strap_q      <= 3'h0;
      wp_meta_q    <= 1'b0;
      wp_q         <= 1'b0;
    end else begin
      scl_sync_q   <= {scl_sync_q[0], scl_in};
      sda_sync_q   <= {sda_sync_q[0], sda_in};
      scl_prev_q   <= scl_s;
      sda_prev_q   <= sda_s;
      strap_meta_q <= device_select_straps;
      strap_q      <= strap_meta_q;
      wp_meta_q    <= write_protect;
      wp_q         <= wp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  // Start and stop are data edges while the clock stays high.
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  reg [2:0]         state_q;
  reg [3:0]         bitcnt_q;
  reg [7:0]         shift_q;
  reg [7:0]         tx_q;
  reg               oe_q;
  reg               space_q;
  reg               wp_cap_q;
  reg [`ADDR_W-1:0] addr_q;
  reg [7:0]         rd_byte;

  reg [1:0]         wstate_q;
  reg [CNT_W-1:0]   wcnt_q;
  reg [`ADDR_W-1:0] waddr_q;
  reg               wspace_q;
  reg               wprot_q;
  reg               lock_q;

  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [7:0] main_rdata;
  wire [7:0] sec_rdata;
  wire [127:0] uid_w = UID_VALUE;

  wire busy = (wstate_q != W_IDLE);
  wire byte_end = scl_fall && (bitcnt_q == `BIT_ACK);

  // Both type codes answer; select bits must equal the straps.
  wire code_ok = (shift_q[`DEVB_CODE_MSB:`DEVB_CODE_LSB] == `CODE_MAIN) ||
                 (shift_q[`DEVB_CODE_MSB:`DEVB_CODE_LSB] == `CODE_SEC);
  wire sel_ok  = (shift_q[`DEVB_SEL_MSB:`DEVB_SEL_LSB] == strap_q);
  wire dev_ok  = code_ok && sel_ok && !busy;

  // A data byte is pushed at the end of its eighth bit, if room is left.
  wire push = byte_end && (state_q == S_WR);

  // A write ends at stop or at a repeated start; queued bytes commit then.
  wire commit = (stop_ev || start_ev) && (state_q == S_WR);

  // Open drain: the output level is always low, only the enable moves.
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;
  assign write_busy = busy;
  assign security_lock_flag = lock_q;

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  // Space bit chooses the array, address bits 10:9 the secured region.
  always @* begin
    rd_byte = `UNMAPPED_BYTE;
    if (!space_q) begin
      rd_byte = main_rdata;
    end else begin
      case (addr_q[`REG_MSB:`REG_LSB])
        `REGION_SEC:  rd_byte = sec_rdata;
        `REGION_UID:  rd_byte = uid_w[{addr_q[3:0], 3'h0} +: 8];
        `REGION_LOCK: rd_byte = {7'h00, lock_q};
        default:      rd_byte = `UNMAPPED_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  // Inputs are taken on clock rises and the line is moved on falls.
  // The first byte of a read is fetched late, at the fall after the
  // acknowledge, so the registered array output has long settled.
  always @(posedge mclk) begin
    if (reset) begin
      state_q  <= S_IDLE;
      bitcnt_q <= `BIT_FIRST;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      oe_q     <= 1'b0;
      space_q  <= 1'b0;
      wp_cap_q <= 1'b0;
      addr_q   <= {`ADDR_W{1'b0}};
    end else if (start_ev) begin
      state_q  <= S_DEV;
      bitcnt_q <= `BIT_FIRST;
      oe_q     <= 1'b0;
      wp_cap_q <= wp_q;
    end else if (stop_ev) begin
      state_q  <= S_IDLE;
      bitcnt_q <= `BIT_FIRST;
      oe_q     <= 1'b0;
    end else if (scl_rise) begin
      if (bitcnt_q != `BIT_ACK) begin
        shift_q  <= {shift_q[6:0], sda_s};
        bitcnt_q <= bitcnt_q + `BIT_ONE;
      end else begin
        bitcnt_q <= `BIT_FIRST;
        // Master acknowledge (our own ack is skipped): low goes on, high ends.
        if (state_q == S_RD && !oe_q) begin
          if (sda_s) begin
            state_q <= S_IDLE;
          end else begin
            addr_q <= addr_step(addr_q, wrap_mask(space_q, addr_q, 1'b1));
          end
        end
      end
    end else if (scl_fall) begin
      if (bitcnt_q == `BIT_ACK) begin
        case (state_q)
          S_DEV: begin
            if (dev_ok) begin
              oe_q    <= 1'b1;
              space_q <= shift_q[`DEVB_SPACE];
              state_q <= shift_q[`DEVB_RW_BIT] ? S_RD : S_AHI;
            end else begin
              state_q <= S_IDLE;
            end
          end
          S_AHI: begin
            addr_q[`ADDR_W-1:`ADDR_W-`AHI_W] <= shift_q[`AHI_W-1:0];
            oe_q    <= 1'b1;
            state_q <= S_ALO;
          end
          S_ALO: begin
            addr_q[7:0] <= shift_q;
            oe_q    <= 1'b1;
            state_q <= S_WR;
          end
          S_WR: begin
            // A full buffer refuses the byte with no acknowledge.
            oe_q <= fifo_in_ready;
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end else if (state_q == S_RD) begin
        if (bitcnt_q == `BIT_FIRST) begin
          tx_q <= rd_byte;
          oe_q <= ~rd_byte[7];
        end else begin
          oe_q <= ~tx_q[`BIT_TOP - bitcnt_q[2:0]];
        end
      end else begin
        oe_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write engine
  // ----------------------------------------------------------------
  wire       drain    = (wstate_q == W_DRAIN) && fifo_out_valid;
  wire [1:0] wregion  = waddr_q[`REG_MSB:`REG_LSB];
  wire       main_we  = drain && !wspace_q && !wprot_q;
  wire       sec_we   = drain && wspace_q && (wregion == `REGION_SEC) &&
                        !wprot_q && !lock_q;
  wire       lock_we  = drain && wspace_q && (wregion == `REGION_LOCK) &&
                        !wprot_q && !lock_q;

  // The identifier region has no write path at all.
  // Protection is judged from the level held at start and at stop, so a
  // level high at either end blocks the write; a pulse between them does not.
  always @(posedge mclk) begin
    if (reset) begin
      wstate_q <= W_IDLE;
      wcnt_q   <= {CNT_W{1'b0}};
      waddr_q  <= {`ADDR_W{1'b0}};
      wspace_q <= 1'b0;
      wprot_q  <= 1'b0;
      lock_q   <= 1'b0;
    end else begin
      if (lock_we && fifo_out_data[0]) begin
        lock_q <= 1'b1;
      end
      case (wstate_q)
        W_IDLE: begin
          if (commit && fifo_out_valid) begin
            wstate_q <= W_DRAIN;
            waddr_q  <= addr_q;
            wspace_q <= space_q;
            wprot_q  <= wp_cap_q | wp_q;
          end
        end
        W_DRAIN: begin
          if (fifo_out_valid) begin
            // Bytes past the page end roll over to its first byte.
            waddr_q <= addr_step(waddr_q, wrap_mask(wspace_q, waddr_q, 1'b0));
          end else if (wprot_q) begin
            wstate_q <= W_IDLE;
          end else begin
            wstate_q <= W_TIME;
            wcnt_q   <= {CNT_W{1'b0}};
          end
        end
        W_TIME: begin
          // New device bytes are refused until the cycle ends.
          if (wcnt_q == WR_LAST) begin
            wstate_q <= W_IDLE;
          end else begin
            wcnt_q <= wcnt_q + 1'b1;
          end
        end
        default: begin
          wstate_q <= W_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Page buffer; its depth caps a page write at one page.
  sewp_fifo #(
    .DW    (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`SEC_AW)
  ) u_fifo (
    .clk       (mclk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_q),
    .out_valid (fifo_out_valid),
    .out_ready (wstate_q == W_DRAIN),
    .out_data  (fifo_out_data)
  );

  // Main array of 4096 bytes.
  sewp_mem #(
    .AW (`MAIN_AW),
    .DW (8)
  ) u_main (
    .clk   (mclk),
    .we    (main_we),
    .waddr (waddr_q[`MAIN_AW-1:0]),
    .wdata (fifo_out_data),
    .raddr (addr_q[`MAIN_AW-1:0]),
    .rdata (main_rdata)
  );

  // Security sector of 32 bytes.
  sewp_mem #(
    .AW (`SEC_AW),
    .DW (8)
  ) u_sec (
    .clk   (mclk),
    .we    (sec_we),
    .waddr (waddr_q[`SEC_AW-1:0]),
    .wdata (fifo_out_data),
    .raddr (addr_q[`SEC_AW-1:0]),
    .rdata (sec_rdata)
  );
endmodule

// >>> verif/sewp_master.sv
`timescale 1ns/100ps
// ------------------------------
// Two-wire bus master model
// ------------------------------
// Data bits move a quarter period after the clock falls, well clear of both edges; start and stop move data with the clock high.
module sewp_master (
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  localparam realtime Q = 31.25;
  // The clock stands high outside frames.
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start();
    #Q pull = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) pull = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  task automatic stop();
    #Q pull = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) pull = 1'b0;
    #(2*Q);
  endtask
  task automatic xfer(input logic b, output logic r);
    #Q pull = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(~more, r);
  endtask
endmodule

// >>> verif/sewp_top_chk.sv
`timescale 1ns/100ps
// ------------------------------
// Pin-level checks of the core
// ------------------------------
module sewp_chk #(
  parameter int WR_CYCLES = 50
)(
  input wire       mclk,
  input wire       reset,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire [2:0] device_select_straps,
  input wire       write_protect,
  input wire       write_busy,
  input wire       security_lock_flag
);
  int busy_len_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Length of the current busy spell, so the write timer can be measured.
  always @(posedge mclk) begin
    if (reset || !write_busy) busy_len_q <= 0;
    else busy_len_q <= busy_len_q + 1;
  end
  // The past term keeps the edge just after reset from counting as a change.
  sequence s_busy_up;
    $rose(write_busy) && !$past(reset);
  endsequence
  sequence s_busy_down;
    $fell(write_busy) && !$past(reset);
  endsequence
  property p_drain_only;
    sda_out == 1'b0 && (sda_oe -> !sda_in);
  endproperty
  property p_out_on_low;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  property p_prot_short;
    s_busy_up ##0 write_protect |-> ##[1:40] !write_busy;
  endproperty
  property p_cycle_bound;
    s_busy_up |-> ##[1:700] !write_busy;
  endproperty
  // Protected writes skip the timer, so they are left out, as is any write once the lock is set.
  property p_cycle_len;
    s_busy_down ##0 (!write_protect && !security_lock_flag) |-> busy_len_q >= WR_CYCLES;
  endproperty
  property p_busy_quiet;
    write_busy |-> !sda_oe;
  endproperty
  property p_lock_keep;
    !$past(reset) |-> !$fell(security_lock_flag);
  endproperty
  property p_lock_set;
    $rose(security_lock_flag) |-> !write_protect ##[0:2] write_busy;
  endproperty
  a_drain_only: assert property (p_drain_only) else $error("data pin driven high");
  a_out_on_low: assert property (p_out_on_low) else $error("data moved in clock high");
  a_prot_short: assert property (p_prot_short) else $error("protected write timed");
  a_cycle_bound: assert property (p_cycle_bound) else $error("write cycle too long");
  a_cycle_len: assert property (p_cycle_len) else $error("write cycle too short");
  a_busy_quiet: assert property (p_busy_quiet) else $error("line pulled while busy");
  a_lock_keep: assert property (p_lock_keep) else $error("lock flag cleared");
  a_lock_set: assert property (p_lock_set) else $error("lock set outside a write");
endmodule
bind sewp_top sewp_chk #(.WR_CYCLES(WR_CYCLES)) i_chk (
  .mclk(mclk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .device_select_straps(device_select_straps),
  .write_protect(write_protect), .write_busy(write_busy),
  .security_lock_flag(security_lock_flag));

// >>> verif/sewp_top_tb.sv
`timescale 1ns/100ps
// ------------------------------
// Self-checking bench
// ------------------------------
module sewp_top_tb;
  localparam int WRC = 500;
  // Identifier value is arbitrary.
  localparam logic [127:0] UIDV = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  logic        mclk;
  logic        reset;
  logic        wp;
  logic [2:0]  straps;
  logic        ack;
  wire         scl;
  wire         pull;
  wire         sda_out;
  wire         oe;
  wire         busy;
  wire         lock;
  wire         sda;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [7:0]  mem [0:4095];
  logic [7:0]  sec [0:31];
  logic [7:0]  wq [0:31];
  logic [7:0]  rq [0:31];
  logic [12:0] a;
  int          n;
  // Open-drain data line with a pull-up; a released line reads high.
  assign sda = (oe ? sda_out : 1'b1) & ~pull;
  sewp_top #(.WR_CYCLES(WRC), .CNT_W(20), .UID_VALUE(UIDV)) i_dut (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(oe), .device_select_straps(straps), .write_protect(wp),
    .write_busy(busy), .security_lock_flag(lock));
  sewp_master i_mst (.scl(scl), .pull(pull), .sda(sda));
  // Clock generator.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Cycle ceiling cuts a hung bus sequence short.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatched %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic done(string name);
    $display("test %s finished", name);
  endtask
  task automatic settle();
    int k;
    k = 0;
    repeat (2) @(posedge mclk);
    while (busy !== 1'b0 && k < 800) begin
      @(posedge mclk);
      k++;
    end
    chk("busy_end", 8'h00, {7'h0, busy});
  endtask
  task automatic fill(int k);
    for (int i = 0; i < k; i++) wq[i] = 8'($urandom);
  endtask
  task automatic hdr(logic [3:0] code, logic [12:0] ad);
    logic k;
    i_mst.start();
    i_mst.wbyte({code, straps, 1'b0}, ack);
    chk("dev_ack", 8'h01, {7'h0, ack});
    i_mst.wbyte({3'h0, ad[12:8]}, k);
    i_mst.wbyte(ad[7:0], k);
  endtask
  task automatic wr(logic [3:0] code, logic [12:0] ad, int k);
    hdr(code, ad);
    for (int i = 0; i < k; i++) i_mst.wbyte(wq[i], ack);
    i_mst.stop();
    settle();
  endtask
  // Random read: dummy write of the address, then a repeated start.
  task automatic rd(logic [3:0] code, logic [12:0] ad, int k);
    hdr(code, ad);
    i_mst.start();
    i_mst.wbyte({code, straps, 1'b1}, ack);
    for (int i = 0; i < k; i++) i_mst.rbyte(i < k - 1, rq[i]);
    i_mst.stop();
  endtask
  task automatic page_chk(logic [12:0] ad);
    rd(4'hA, {ad[12:5], 5'h0}, 32);
    for (int i = 0; i < 32; i++)
      if (!$isunknown(mem[{ad[11:5], 5'(i)}])) chk("main", mem[{ad[11:5], 5'(i)}], rq[i]);
  endtask
  task automatic sec_chk();
    rd(4'hB, 13'($urandom) & 13'h19E0, 32);
    for (int i = 0; i < 32; i++) chk("sector", sec[i], rq[i]);
  endtask
  // Main sequence: reset, wp and straps move by non-blocking assignment at the clock edge; the bus pins move on the master's delays.
  initial begin
    reset = 1'b1;
    wp = 1'b0;
    straps = 3'h0;
    void'($urandom(32'h58a6));
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    straps <= 3'($urandom);
    repeat (6) @(posedge mclk);
    chk("lock_reset", 8'h00, {7'h0, lock});
    for (int t = 0; t < 4; t++) begin
      a = 13'($urandom);
      n = (t == 3) ? 32 : 1 + $urandom % 8;
      if (t == 3) a[4:0] = 5'h1F;
      fill(n);
      wr(4'hA, a, n);
      for (int i = 0; i < n; i++) mem[{a[11:5], a[4:0] + 5'(i)}] = wq[i];
      page_chk(a);
    end
    done("main_page");
    @(posedge mclk) wp <= 1'b1;
    fill(8);
    wr(4'hA, a, 8);
    page_chk(a);
    @(posedge mclk) wp <= 1'b0;
    done("protect");
    for (int k = 0; k < 24; k++) begin
      i_mst.start();
      i_mst.wbyte({k < 16 ? 4'(k) : 4'hA, k < 16 ? straps : 3'(k), 1'b0}, ack);
      i_mst.stop();
      chk("select", {7'h0, k < 16 ? k[3:1] == 3'h5 : k[2:0] == straps}, {7'h0, ack});
    end
    fill(1);
    wr(4'hA, 13'h0, 1);
    mem[0] = wq[0];
    hdr(4'hA, 13'h0);
    i_mst.wbyte(wq[0], ack);
    i_mst.stop();
    i_mst.start();
    i_mst.wbyte({4'hA, straps, 1'b0}, ack);
    i_mst.stop();
    chk("busy_nack", 8'h00, {7'h0, ack});
    settle();
    done("select_busy");
    fill(32);
    wr(4'hB, 13'($urandom) & 13'h19E0, 32);
    for (int i = 0; i < 32; i++) sec[i] = wq[i];
    sec_chk();
    fill(16);
    wr(4'hB, 13'h0200 | (13'($urandom) & 13'h19F0), 16);
    a = 13'h0200 | (13'($urandom) & 13'h19FF);
    rd(4'hB, a, 16);
    for (int i = 0; i < 16; i++) chk("uid", UIDV[8*4'(a[3:0] + i) +: 8], rq[i]);
    done("sector_uid");
    wq[0] = 8'h01;
    wr(4'hB, 13'h0400 | (13'($urandom) & 13'h19FF), 1);
    chk("lock_flag", 8'h01, {7'h0, lock});
    rd(4'hB, 13'h0400, 1);
    chk("lock_read", 8'h01, rq[0]);
    fill(32);
    wr(4'hB, 13'h0000, 32);
    sec_chk();
    wq[0] = 8'h00;
    wr(4'hB, 13'h0400, 1);
    chk("lock_stays", 8'h01, {7'h0, lock});
    done("lock");
    results();
  end
endmodule
